//--- exec_pkg.sv
// Shared constants and types for the shift, move and indirect load unit
package exec_pkg;
  // Register byte offsets on the Avalon slave
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_WREG = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h0C;
  localparam logic [7:0] OFS_PTR0 = 8'h10;
  localparam logic [7:0] OFS_PTR1 = 8'h14;
  // Command register field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST_BIT = 4;
  localparam int CMD_SEL_BIT = 5;
  localparam int CMD_MODE_LSB = 6;
  localparam int CMD_ARG_LSB = 8;
  // Status register bit positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_CARRY_BIT = 1;
  localparam int ST_ZERO_BIT = 2;
  // Reset values
  localparam logic [15:0] RST_CMD = 16'h0000;
  localparam logic [7:0] RST_WREG = 8'h00;
  localparam logic [4:0] RST_BANK = 5'h00;
  localparam logic [15:0] RST_PTR = 16'h0000;
  // Instruction selector held in the command register
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SHIFT = 3'h1,
    OP_MOVE = 3'h2,
    OP_IND = 3'h3,
    OP_IND_REL = 3'h4
  } op_t;
  // Pointer update mode codes
  typedef enum logic [1:0] {
    PRE_INC = 2'h0,
    PRE_DEC = 2'h1,
    POST_INC = 2'h2,
    POST_DEC = 2'h3
  } mode_t;
endpackage : exec_pkg

//--- exec_if.sv
// Interface joining the sequencer to its datapath and pointer units
`timescale 1ns/10ps
`default_nettype none
interface exec_if;
  exec_pkg::op_t op;        // Instruction being executed
  logic [7:0] operand;      // Byte read from data memory
  logic carry_in;           // Carry before the instruction
  logic [7:0] result;       // Byte to store
  logic carry_out;          // Carry after the instruction
  logic zero_out;           // Result is zero
  logic [15:0] ptr_in;      // Selected pointer value
  exec_pkg::mode_t mode;    // Pointer update mode
  logic [5:0] offset;       // Signed relative offset
  logic relative;           // Relative offset form
  logic [15:0] eff_addr;    // Effective address
  logic [15:0] ptr_next;    // Pointer after the load
  modport ctl (output op, operand, carry_in, ptr_in, mode, offset, relative,
               input result, carry_out, zero_out, eff_addr, ptr_next);
  modport alu (input op, operand, carry_in, output result, carry_out, zero_out);
  modport ptr (input ptr_in, mode, offset, relative, output eff_addr, ptr_next);
endinterface : exec_if
`default_nettype wire

//--- shift_move_alu.sv
// Result and flag logic for the shift, move and indirect load
`timescale 1ns/10ps
`default_nettype none
module shift_move_alu (
  exec_if.alu ex // Operand in, result and flags out
);
  // Shift pulls a zero into the top; everything else passes through
  always_comb begin
    if (ex.op == exec_pkg::OP_SHIFT) begin
      ex.result = {1'b0, ex.operand[7:1]};
      ex.carry_out = ex.operand[0];
    end else begin
      // Move and indirect load leave carry alone
      ex.result = ex.operand;
      ex.carry_out = ex.carry_in;
    end
    ex.zero_out = (ex.result == 8'h00);
  end
endmodule : shift_move_alu
`default_nettype wire

//--- pointer_step.sv
// Effective address and pointer update for the indirect load
`timescale 1ns/10ps
`default_nettype none
module pointer_step (
  exec_if.ptr px // Pointer and mode in, address and new pointer out
);
  // Sign extends the six-bit offset to pointer width
  function automatic logic [15:0] sext6(input logic [5:0] k);
    sext6 = {{10{k[5]}}, k};
  endfunction : sext6

  // Plain 16-bit arithmetic, so both ends wrap around by themselves
  always_comb begin
    if (px.relative) begin
      px.eff_addr = px.ptr_in + sext6(px.offset);
      px.ptr_next = px.ptr_in;
    end else begin
      unique case (px.mode)
        exec_pkg::PRE_INC: begin
          px.eff_addr = px.ptr_in + 16'h0001;
          px.ptr_next = px.ptr_in + 16'h0001;
        end
        exec_pkg::PRE_DEC: begin
          px.eff_addr = px.ptr_in - 16'h0001;
          px.ptr_next = px.ptr_in - 16'h0001;
        end
        exec_pkg::POST_INC: begin
          px.eff_addr = px.ptr_in; // Use then step
          px.ptr_next = px.ptr_in + 16'h0001;
        end
        exec_pkg::POST_DEC: begin
          px.eff_addr = px.ptr_in; // Use then step
          px.ptr_next = px.ptr_in - 16'h0001;
        end
      endcase
    end
  end
endmodule : pointer_step
`default_nettype wire

//--- shift_move_indirect_exec.sv
// Sequencer, Avalon register slave and memory port of the exec unit
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module shift_move_indirect_exec (
  input wire logic core_clk,              // Core clock, 10 MHz
  input wire logic sys_rst,               // Asynchronous reset, active high
  input wire logic [7:0] avs_address,     // Byte address
  input wire logic avs_read,              // Read request
  input wire logic avs_write,             // Write request
  input wire logic [31:0] avs_writedata,  // Write data
  input wire logic [3:0] avs_byteenable,  // Byte lanes of a write
  output logic [31:0] avs_readdata,       // Read data
  output logic avs_waitrequest,           // Slave not ready
  output logic [15:0] mem_addr,           // Data memory address
  output logic mem_rd,                    // Data memory read strobe
  output logic mem_wr,                    // Data memory write strobe
  output logic [7:0] mem_wdata,           // Data memory write byte
  input wire logic [7:0] mem_rdata        // Byte, valid cycle after mem_rd
);
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ISSUE = 5'b00010,
    ST_READ = 5'b00100,
    ST_DONE = 5'b01000,
    ST_WBACK = 5'b10000
  } state_t;

  // All state of the block
  typedef struct packed {
    state_t st;          // Sequencer state
    logic ack;           // Bus answer given this cycle
    logic waitreq;       // Registered waitrequest
    logic [31:0] rdata;  // Registered read data
    logic [15:0] cmd;    // Last command word
    logic [7:0] wreg;    // Working register
    logic carry;         // Carry flag
    logic zero;          // Zero flag
    logic [4:0] bank;    // Current bank
    logic [15:0] ptr0;   // Pointer 0
    logic [15:0] ptr1;   // Pointer 1
    logic [15:0] maddr;  // Memory address
    logic mrd;           // Memory read strobe
    logic mwr;           // Memory write strobe
    logic [7:0] mwdata;  // Memory write byte
  } core_t;

  core_t cur; // Registered state
  core_t nxt; // Next state
  exec_if ex (); // Link to the datapath units

  // Merges write data into an old word lane by lane
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge_be = m;
  endfunction : merge_be

  // Command fields
  exec_pkg::op_t cmd_op; // Instruction
  logic cmd_dest;        // Destination select
  logic cmd_sel;         // Pointer index
  logic [6:0] cmd_file;  // File address within bank
  assign cmd_op = exec_pkg::op_t'(cur.cmd[exec_pkg::CMD_OP_LSB +: 3]);
  assign cmd_dest = cur.cmd[exec_pkg::CMD_DEST_BIT];
  assign cmd_sel = cur.cmd[exec_pkg::CMD_SEL_BIT];
  assign cmd_file = cur.cmd[exec_pkg::CMD_ARG_LSB +: 7];

  // Feed the units from the command and the memory byte
  assign ex.op = cmd_op;
  assign ex.operand = mem_rdata;
  assign ex.carry_in = cur.carry;
  assign ex.ptr_in = cmd_sel ? cur.ptr1 : cur.ptr0;
  assign ex.mode = exec_pkg::mode_t'(cur.cmd[exec_pkg::CMD_MODE_LSB +: 2]);
  assign ex.offset = cur.cmd[exec_pkg::CMD_ARG_LSB +: 6];
  assign ex.relative = (cmd_op == exec_pkg::OP_IND_REL);

  shift_move_alu u_alu (
    .ex (ex.alu)
  );

  pointer_step u_ptr (
    .px (ex.ptr)
  );

  // Bus decode helpers
  logic bus_req;       // Read or write pending
  logic busy;          // Instruction in flight
  logic stall;         // Write refused until idle
  logic is_ind;        // Command holds an indirect load
  logic [31:0] rdv;    // Current value at the bus address
  logic [31:0] wm;     // Merged write word
  assign bus_req = avs_read | avs_write;
  assign busy = (cur.st != ST_IDLE);
  // Writes wait while busy so software never races the sequencer
  assign stall = avs_write & busy;
  assign is_ind = (cmd_op == exec_pkg::OP_IND) | (cmd_op == exec_pkg::OP_IND_REL);

  // Read view of the register map; unmapped reads as zero
  always_comb begin
    rdv = '0;
    unique case (avs_address)
      exec_pkg::OFS_CMD: rdv[15:0] = cur.cmd;
      exec_pkg::OFS_STATUS: begin
        rdv[exec_pkg::ST_BUSY_BIT] = busy;
        rdv[exec_pkg::ST_CARRY_BIT] = cur.carry;
        rdv[exec_pkg::ST_ZERO_BIT] = cur.zero;
      end
      exec_pkg::OFS_WREG: rdv[7:0] = cur.wreg;
      exec_pkg::OFS_BANK: rdv[4:0] = cur.bank;
      exec_pkg::OFS_PTR0: rdv[15:0] = cur.ptr0;
      exec_pkg::OFS_PTR1: rdv[15:0] = cur.ptr1;
      default: rdv = '0;
    endcase
    wm = merge_be(rdv, avs_writedata, avs_byteenable);
  end

  // Next state: bus slave and instruction sequencer
  always_comb begin
    nxt = cur;
    nxt.ack = 1'b0;
    nxt.mrd = 1'b0;
    nxt.mwr = 1'b0;
    // Answer once per request, one cycle after it is seen
    if (bus_req && !cur.ack && !stall) begin
      nxt.ack = 1'b1;
      if (avs_read) begin
        nxt.rdata = rdv;
      end
      if (avs_write) begin
        unique case (avs_address)
          exec_pkg::OFS_CMD: begin
            nxt.cmd = wm[15:0];
            // Known opcodes start; others are only stored
            if (wm[2:0] != 3'h0 && wm[2:0] <= 3'h4) begin
              nxt.st = ST_ISSUE;
            end
          end
          exec_pkg::OFS_WREG: nxt.wreg = wm[7:0];
          exec_pkg::OFS_BANK: nxt.bank = wm[4:0];
          exec_pkg::OFS_PTR0: nxt.ptr0 = wm[15:0];
          exec_pkg::OFS_PTR1: nxt.ptr1 = wm[15:0];
          default: ; // Status is read-only; unmapped writes vanish
        endcase
      end
    end
    nxt.waitreq = !nxt.ack;
    // Sequencer
    unique case (cur.st)
      ST_IDLE: ;
      ST_ISSUE: begin
        // Indirect goes through the pointer; the port itself holds nothing
        nxt.maddr = is_ind ? ex.eff_addr : {4'h0, cur.bank, cmd_file};
        nxt.mrd = 1'b1;
        nxt.st = ST_READ;
      end
      ST_READ: nxt.st = ST_DONE;
      ST_DONE: begin
        nxt.zero = ex.zero_out;
        nxt.carry = ex.carry_out;
        nxt.st = ST_IDLE;
        if (is_ind) begin
          nxt.wreg = ex.result;
          if (cmd_sel) begin
            nxt.ptr1 = ex.ptr_next;
          end else begin
            nxt.ptr0 = ex.ptr_next;
          end
        end else if (cmd_dest) begin
          nxt.mwr = 1'b1;
          nxt.mwdata = ex.result;
          nxt.st = ST_WBACK;
        end else begin
          nxt.wreg = ex.result;
        end
      end
      ST_WBACK: nxt.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= '{st: ST_IDLE, ack: 1'b0, waitreq: 1'b1, rdata: '0,
               cmd: exec_pkg::RST_CMD, wreg: exec_pkg::RST_WREG,
               carry: 1'b0, zero: 1'b0, bank: exec_pkg::RST_BANK,
               ptr0: exec_pkg::RST_PTR, ptr1: exec_pkg::RST_PTR,
               maddr: 16'h0000, mrd: 1'b0, mwr: 1'b0, mwdata: 8'h00};
    end else begin
      cur <= nxt;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata = cur.rdata;
  assign avs_waitrequest = cur.waitreq;
  assign mem_addr = cur.maddr;
  assign mem_rd = cur.mrd;
  assign mem_wr = cur.mwr;
  assign mem_wdata = cur.mwdata;

  // Reference values for the checks below
  logic [7:0] shift_ref; // Expected shifted byte
  logic lsb_ref;         // Expected carry
  logic [15:0] rel_ref;  // Expected relative address
  logic issue_ind;       // Indirect issue without offset
  assign shift_ref = {1'b0, mem_rdata[7:1]};
  assign lsb_ref = mem_rdata[0];
  assign rel_ref = ex.ptr_in + {{10{ex.offset[5]}}, ex.offset};
  assign issue_ind = (cur.st == ST_ISSUE) && (cmd_op == exec_pkg::OP_IND);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Steps of one instruction
  sequence seq_read_phase;
    (cur.st == ST_READ) && mem_rd ##1 (cur.st == ST_DONE) && !mem_rd;
  endsequence
  sequence seq_finish;
    (cur.st == ST_IDLE) || ((cur.st == ST_WBACK) && mem_wr);
  endsequence

  // Shift to the work register pulls a zero into the top bit
  a_shift_msb: assert property (
    (cur.st == ST_DONE) && (cmd_op == exec_pkg::OP_SHIFT) && !cmd_dest
    |=> cur.wreg == $past(shift_ref))
    else $error("shift result wrong");
  // Bit 0 lands in carry; zero follows the shifted byte
  a_shift_carry: assert property (
    (cur.st == ST_DONE) && (cmd_op == exec_pkg::OP_SHIFT)
    |=> (cur.carry == $past(lsb_ref)) && (cur.zero == ($past(shift_ref) == 8'h00)))
    else $error("shift flags wrong");
  // Destination 1 writes back and leaves the work register alone
  a_shift_dest: assert property (
    (cur.st == ST_DONE) && (cmd_op == exec_pkg::OP_SHIFT) && cmd_dest
    |=> mem_wr && (mem_wdata == $past(shift_ref)) && (cur.wreg == $past(cur.wreg)))
    else $error("shift destination wrong");
  // Move with destination 0 copies into the work register only
  a_move_work: assert property (
    (cur.st == ST_DONE) && (cmd_op == exec_pkg::OP_MOVE) && !cmd_dest
    |=> (cur.wreg == $past(mem_rdata)) && !mem_wr)
    else $error("move to work wrong");
  // Move with destination 1 rewrites the byte in place
  a_move_dest: assert property (
    (cur.st == ST_DONE) && (cmd_op == exec_pkg::OP_MOVE) && cmd_dest
    |=> mem_wr && (mem_wdata == $past(mem_rdata)) && (cur.wreg == $past(cur.wreg)))
    else $error("move write-back wrong");
  // Zero follows the moved byte whatever the destination
  a_move_zero: assert property (
    (cur.st == ST_DONE) && (cmd_op == exec_pkg::OP_MOVE)
    |=> cur.zero == ($past(mem_rdata) == 8'h00))
    else $error("move zero flag wrong");
  // Index 1 picks the second pointer
  a_ptr_select: assert property (
    issue_ind && cmd_sel && (ex.mode == exec_pkg::PRE_INC)
    |=> mem_addr == $past(cur.ptr1) + 16'h0001)
    else $error("pointer select wrong");
  // Predecrement reads one below the pointer
  a_ptr_dec: assert property (
    issue_ind && !cmd_sel && (ex.mode == exec_pkg::PRE_DEC)
    |=> mem_addr == $past(cur.ptr0) - 16'h0001)
    else $error("predecrement address wrong");
  // Relative form adds the signed offset to the pointer
  a_rel_addr: assert property (
    (cur.st == ST_ISSUE) && (cmd_op == exec_pkg::OP_IND_REL)
    |=> mem_rd && (mem_addr == $past(rel_ref)))
    else $error("relative address wrong");
  // Postincrement leaves the pointer one up once the load ends
  a_ptr_after: assert property (
    issue_ind && !cmd_sel && (ex.mode == exec_pkg::POST_INC)
    |=> ##2 cur.ptr0 == $past(cur.ptr0, 3) + 16'h0001)
    else $error("pointer not stepped");
  // Relative form never moves either pointer
  a_rel_keep: assert property (
    (cur.st == ST_ISSUE) && (cmd_op == exec_pkg::OP_IND_REL)
    |=> ##2 (cur.ptr0 == $past(cur.ptr0, 3)) && (cur.ptr1 == $past(cur.ptr1, 3)))
    else $error("relative pointer moved");
  // The loaded byte reaches the work register and sets zero
  a_ind_zero: assert property (
    (cur.st == ST_DONE) && is_ind
    |=> (cur.wreg == $past(mem_rdata)) && (cur.zero == ($past(mem_rdata) == 8'h00)))
    else $error("indirect load wrong");
  // The port holds nothing, so an indirect load never stores
  a_ind_no_store: assert property (
    busy && is_ind |-> !mem_wr)
    else $error("indirect load wrote memory");
  // Postdecrement from zero wraps to the top of the range
  a_ptr_wrap: assert property (
    issue_ind && !cmd_sel && (ex.mode == exec_pkg::POST_DEC) && (cur.ptr0 == 16'h0000)
    |=> ##2 cur.ptr0 == 16'hFFFF)
    else $error("pointer did not wrap");
  // Move: banked address, one read, then done or write-back
  a_move_steps: assert property (
    (cur.st == ST_ISSUE) && (cmd_op == exec_pkg::OP_MOVE)
    |=> (mem_addr == {4'h0, cur.bank, cmd_file}) ##0 seq_read_phase ##1 seq_finish)
    else $error("move sequence wrong");
  // One answer per request, low for exactly one cycle
  a_bus_answer: assert property (
    bus_req && !cur.ack && !stall |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");
  // A write while busy is held off until the sequencer is idle
  a_write_stall: assert property (
    stall |=> avs_waitrequest)
    else $error("write not stalled");
  // Memory strobes are single-cycle pulses
  a_mem_pulse: assert property (
    mem_rd || mem_wr |=> !mem_rd && !mem_wr)
    else $error("memory strobe too long");
endmodule : shift_move_indirect_exec
`default_nettype wire

//--- data_mem_model.sv
// Behavioural data memory on the far side of the unit's byte port
`timescale 1ns/10ps
`default_nettype none
module data_mem_model (
  input wire logic core_clk, // Core clock
  input wire logic [15:0] mem_addr, // Byte address
  input wire logic mem_rd, // Read strobe
  input wire logic mem_wr, // Write strobe
  input wire logic [7:0] mem_wdata, // Byte to write
  output logic [7:0] mem_rdata // Byte, valid the cycle after mem_rd
);
  logic [7:0] store [0:65535]; // Whole 16-bit space, loaded by the bench
  int rd_cnt = 0; // Reads seen
  int wr_cnt = 0; // Writes seen
  logic [15:0] last_rd = 16'h0000; // Address of the latest read
  initial mem_rdata = 8'h00;
  // Data is good for one cycle only; the inverse otherwise, so a late sample shows
  always @(posedge core_clk) begin
    if (mem_rd) begin
      mem_rdata <= store[mem_addr];
      rd_cnt <= rd_cnt + 1;
      last_rd <= mem_addr;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_wr) begin
      store[mem_addr] <= mem_wdata;
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule : data_mem_model
`default_nettype wire

//--- shift_move_indirect_exec_test.sv
// Self-checking bench of the shift, move and indirect load unit
`timescale 1ns/10ps
`default_nettype none
module shift_move_indirect_exec_test;
  logic core_clk = 1'b0; // 10 MHz clock
  logic sys_rst = 1'b1; // Reset, held at start
  logic [7:0] avs_address = 8'h00; // Bus address
  logic avs_read = 1'b0; // Bus read
  logic avs_write = 1'b0; // Bus write
  logic [31:0] avs_writedata = 32'h0000_0000; // Bus write data
  logic [3:0] avs_byteenable = 4'hF; // All lanes
  logic [31:0] avs_readdata; // Bus read data
  logic avs_waitrequest; // Bus stall
  logic [15:0] mem_addr; // Memory address
  logic mem_rd; // Memory read
  logic mem_wr; // Memory write
  logic [7:0] mem_wdata; // Memory write byte
  logic [7:0] mem_rdata; // Memory read byte
  int error_cnt = 0; // Mismatches
  int n_compared = 0; // Comparisons
  logic [7:0] exp_w; // Expected work register
  logic exp_c; // Expected carry
  logic exp_z; // Expected zero flag
  shift_move_indirect_exec dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  data_mem_model mem_i (.core_clk(core_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // Half period of 50 ns
  always #50 core_clk = ~core_clk;
  // Closing report, also reached when a wait runs out
  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  // Single comparison point
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      error_cnt++;
      print_verdict();
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  // Read and compare in one go
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask : rd_chk
  // Start an instruction and poll busy under a bound
  task automatic exec(input logic [31:0] cmd);
    logic [31:0] q;
    int i;
    wr(exec_pkg::OFS_CMD, cmd);
    for (i = 0; i < 10; i++) begin
      bus(1'b0, exec_pkg::OFS_STATUS, 32'h0000_0000, q);
      if (q[exec_pkg::ST_BUSY_BIT] === 1'b0) break;
    end
    if (i == 10) begin
      error_cnt++;
      print_verdict();
    end
    rd_chk(exec_pkg::OFS_STATUS, {29'h0, exp_z, exp_c, 1'b0});
    rd_chk(exec_pkg::OFS_WREG, {24'h0, exp_w});
  endtask : exec
  initial begin
    logic [7:0] v, r, w;
    logic [6:0] f;
    logic [4:0] bank;
    logic [15:0] a, p, ea, np;
    logic [5:0] off;
    logic [1:0] m;
    logic [2:0] op;
    logic d, n;
    int k, it, wc, rc;
    void'($urandom(32'h4c2f0d2b));
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    exp_w = 8'h00;
    exp_c = 1'b0;
    exp_z = 1'b0;
    // Reset values, and an unmapped place that reads zero after a write to another one at 1C
    wr(8'h1C, 32'hFFFF_FFFF);
    for (k = 0; k < 7; k++) rd_chk(8'(k * 4), 32'h0000_0000);
    $display("test reset done");
    // Shift then move, corner bytes first, both destinations
    for (k = 0; k < 16; k++) begin
      op = (k < 8) ? 3'(exec_pkg::OP_SHIFT) : 3'(exec_pkg::OP_MOVE);
      v = (k % 8 == 0) ? 8'h01 : (k % 8 == 1) ? 8'h00 : 8'($urandom);
      f = 7'($urandom);
      bank = 5'($urandom);
      d = k[0] ^ k[1];
      w = 8'($urandom);
      a = {4'h0, bank, f};
      mem_i.store[a] = v;
      wr(exec_pkg::OFS_BANK, {27'h0, bank});
      wr(exec_pkg::OFS_WREG, {24'h0, w});
      r = (k < 8) ? {1'b0, v[7:1]} : v;
      if (k < 8) exp_c = v[0];
      exp_z = (r == 8'h00);
      exp_w = d ? w : r;
      wc = mem_i.wr_cnt;
      exec({17'h0, f, 2'b00, 1'b0, d, 1'b0, op});
      check({16'h0, mem_i.last_rd}, {16'h0, a});
      check(32'(mem_i.wr_cnt - wc), {31'h0, d});
      check({24'h0, mem_i.store[a]}, {24'h0, d ? r : v});
    end
    $display("test shift and move done");
    // Indirect load: both pointers, every mode, wrap corners
    for (k = 0; k < 30; k++) begin
      n = k[0];
      it = k / 10;
      op = ((k / 2) % 5 == 4) ? 3'(exec_pkg::OP_IND_REL) : 3'(exec_pkg::OP_IND);
      m = ((k / 2) % 5 == 4) ? 2'($urandom) : 2'((k / 2) % 5);
      p = (it == 0) ? 16'hFFFF : (it == 1) ? 16'h0000 : 16'($urandom);
      off = (it == 0) ? 6'h20 : (it == 1) ? 6'h1F : 6'($urandom);
      v = (k % 7 == 3) ? 8'h00 : 8'($urandom);
      wr(n ? exec_pkg::OFS_PTR1 : exec_pkg::OFS_PTR0, {16'h0, p});
      wr(n ? exec_pkg::OFS_PTR0 : exec_pkg::OFS_PTR1, 32'h0000_5A5A);
      if (op == 3'(exec_pkg::OP_IND_REL)) begin
        ea = p + {{10{off[5]}}, off};
        np = p;
      end else begin
        ea = (m == 2'h0) ? p + 16'h0001 : (m == 2'h1) ? p - 16'h0001 : p;
        np = m[0] ? p - 16'h0001 : p + 16'h0001;
      end
      mem_i.store[ea] = v;
      exp_w = v;
      exp_z = (v == 8'h00);
      wc = mem_i.wr_cnt;
      exec({17'h0, 1'b0, off, m, n, 1'b0, 1'b0, op});
      check({16'h0, mem_i.last_rd}, {16'h0, ea});
      rd_chk(n ? exec_pkg::OFS_PTR1 : exec_pkg::OFS_PTR0, {16'h0, np});
      rd_chk(n ? exec_pkg::OFS_PTR0 : exec_pkg::OFS_PTR1, 32'h0000_5A5A);
      check(32'(mem_i.wr_cnt - wc), 32'h0000_0000);
    end
    $display("test indirect load done");
    // Unused selector codes are stored but start nothing
    for (k = 0; k < 4; k++) begin
      op = (k == 0) ? 3'h0 : 3'(k + 4);
      rc = mem_i.rd_cnt;
      exec({24'h0, 8'(op)});
      rd_chk(exec_pkg::OFS_CMD, {24'h0, 8'(op)});
      check(32'(mem_i.rd_cnt - rc), 32'h0000_0000);
    end
    $display("test idle codes done");
    // A write during a write-back shift waits, then lands after it
    mem_i.store[16'h0000] = 8'h81;
    wr(exec_pkg::OFS_BANK, 32'h0000_0000);
    wr(exec_pkg::OFS_CMD, 32'h0000_0011);
    wr(exec_pkg::OFS_WREG, 32'h0000_00C3);
    check({24'h0, mem_i.store[16'h0000]}, 32'h0000_0040);
    rd_chk(exec_pkg::OFS_STATUS, 32'h0000_0002);
    rd_chk(exec_pkg::OFS_WREG, 32'h0000_00C3);
    // Unset byte lanes keep their old value
    wr(exec_pkg::OFS_PTR0, 32'h0000_1234);
    avs_byteenable <= 4'h1;
    wr(exec_pkg::OFS_PTR0, 32'hFFFF_FF78);
    avs_byteenable <= 4'hF;
    rd_chk(exec_pkg::OFS_PTR0, 32'h0000_1278);
    $display("test stall and lanes done");
    // Reset in mid-run brings every register back to its reset value
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 6; k++) rd_chk(8'(k * 4), 32'h0000_0000);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule : shift_move_indirect_exec_test
`default_nettype wire
